// *** dv/mdm_regfile_model.sv ***
// Register file model that takes result words on their write strobes.
`timescale 1ns/100ps
`default_nettype none
module mdm_regfile_model (
  // Clock
  input wire logic mclk_i,
  // Result words and strobes
  input wire logic [3:0] we_i,
  input wire logic [63:0] word_i,
  // Stored pairs
  output logic [63:0] regs_o
);
  // ****
  // Storage
  // ****
  // A word lands only on its own strobe, so a spurious or missing write shows.
  always @(posedge mclk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (we_i[i]) regs_o[16*i +: 16] <= word_i[16*i +: 16];
    end
  end
endmodule
`default_nettype wire

// *** dv/mdm_unit_sva.sv ***
// Port checker of the multiply, divide and accumulate unit.
`timescale 1ns/100ps
`default_nettype none
module mdm_unit_sva (
  // Watched ports
  input wire logic mclk_i, rstn_i, start_i, fetch_ram_i, acc_low_we_i,
  input wire logic busy_o, done_o, we_low_o, we_mult_o, we_rest_o, flags_we_o,
  input wire logic carry_flag_o, aux_carry_flag_o,
  input wire logic [2:0] op_i,
  input wire logic [15:0] acc_wdata_i, mac_acc_low_o
);
  // ****
  // Checks
  // ****
  wire take = start_i && !busy_o;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  mul8_lat_a: assert property (take && op_i == 3'h0 && !fetch_ram_i |=> busy_o ##1 done_o && we_low_o) else $error("mul8 timing");
  mul16_lat_a: assert property (take && (op_i == 3'h1 || op_i == 3'h2) && !fetch_ram_i |=>
    busy_o [*2] ##1 done_o && we_mult_o && !flags_we_o) else $error("mul16 timing");
  div16_lat_a: assert property (take && op_i == 3'h3 && !fetch_ram_i |=>
    busy_o [*8] ##1 busy_o ##1 done_o && we_rest_o) else $error("div16 timing");
  div32_lat_a: assert property (take && op_i == 3'h4 && !fetch_ram_i |-> ##18 done_o && we_mult_o) else $error("div32 timing");
  mac_lat_a: assert property (take && op_i[2:1] == 2'h3 && !fetch_ram_i |=> busy_o [*3] ##1 done_o && flags_we_o) else $error("mac timing");
  ram_lat_a: assert property (take && fetch_ram_i && op_i == 3'h0 |=> busy_o [*5] ##1 done_o) else $error("ram fetch timing");
  flag_keep_a: assert property (!flags_we_o |-> $stable({carry_flag_o, aux_carry_flag_o})) else $error("flags moved");
  hold_end_a: assert property (done_o |-> !busy_o && $past(busy_o)) else $error("hold ended wrongly");
  acc_half_a: assert property (!busy_o && !start_i && acc_low_we_i |=> mac_acc_low_o == $past(acc_wdata_i)) else $error("low half");
  cover property (take && op_i == 3'h6);
  cover property (take && fetch_ram_i);
  cover property (flags_we_o && carry_flag_o);
endmodule
`default_nettype wire

// *** dv/mdm_unit_test.sv ***
// Self-checking bench of the multiply, divide and accumulate unit.
`timescale 1ns/100ps
`default_nettype none
module mdm_unit_test;
  logic mclk_i = 0, rstn_i = 0, start_i = 0, fetch_ram_i = 0, acc_high_we_i = 0, acc_low_we_i = 0;
  logic [2:0] op_i = 0;
  logic [7:0] acc8_i = 0, x_reg_i = 0;
  logic [15:0] low_word_pair_i = 0, multiplier_pair_i = 0, rest_pair_i = 0, divisor_high_i = 0;
  logic [15:0] acc_wdata_i = 0;
  wire busy_o, done_o, we_low_o, we_mult_o, we_rest_o, we_div_high_o, flags_we_o;
  wire carry_flag_o, aux_carry_flag_o;
  wire [15:0] low_word_pair_o, multiplier_pair_o, rest_pair_o, divisor_high_o;
  wire [15:0] mac_acc_high_o, mac_acc_low_o;
  wire [63:0] regs;
  logic [63:0] exp_regs = 0;
  logic [31:0] acc = 0;
  logic cy = 0, ac = 0;
  int err_count = 0, check_count = 0, cyc = 0;
  mdm_unit mdm_unit_inst (.*);
  mdm_regfile_model mdm_regfile_model_inst (.mclk_i(mclk_i),
    .we_i({we_div_high_o, we_rest_o, we_mult_o, we_low_o}),
    .word_i({divisor_high_o, rest_pair_o, multiplier_pair_o, low_word_pair_o}), .regs_o(regs));
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run;
    end
  end
  // ****
  // Tasks
  // ****
  task check(input string what, input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Works out the new pairs, accumulator and flags; returns the base clock count.
  function automatic int predict(input logic [2:0] op);
    logic [31:0] p, d, s;
    logic [16:0] lo;
    if (op == 3'h2 || op == 3'h6) p = $signed(low_word_pair_i) * $signed(multiplier_pair_i);
    else p = low_word_pair_i * multiplier_pair_i;
    d = {divisor_high_i, rest_pair_i};
    s = {multiplier_pair_i, low_word_pair_i};
    case (op)
      3'h0: begin exp_regs[15:0] = acc8_i * x_reg_i; return 1; end
      3'h1, 3'h2: begin exp_regs[31:0] = p; return 2; end
      3'h3: begin
        exp_regs[15:0] = rest_pair_i == 0 ? 16'hFFFF : low_word_pair_i / rest_pair_i;
        exp_regs[47:32] = rest_pair_i == 0 ? low_word_pair_i : low_word_pair_i % rest_pair_i;
        return 9;
      end
      3'h4: begin exp_regs = d == 0 ? {s, 32'hFFFFFFFF} : {s % d, s / d}; return 17; end
      default: begin
        lo = acc[15:0] + p[15:0];
        {cy, s} = acc + p;
        if (op == 3'h6) cy = acc[31] == p[31] && s[31] != acc[31];
        ac = lo[16];
        acc = s;
        return 3;
      end
    endcase
  endfunction
  task run(input logic [2:0] op, input logic ram);
    int n, want;
    op_i = op;
    fetch_ram_i = ram;
    start_i = 1;
    want = predict(op);
    want = ram ? 2 * want + 3 : want;
    @(posedge mclk_i);
    #1 start_i = 0;
    acc_low_we_i = 1;
    acc_wdata_i = 16'h5A5A;
    n = 0;
    while (done_o !== 1'h1 && n < 60) begin
      @(posedge mclk_i);
      #1 n++;
    end
    acc_low_we_i = 0;
    check("clocks", n, want);
    check("flags", {carry_flag_o, aux_carry_flag_o}, {cy, ac});
    check("accumulator", {mac_acc_high_o, mac_acc_low_o}, acc);
    // The idle cycle after each operation stands where software puts its no-op.
    @(posedge mclk_i);
    #1 check("pairs", regs, exp_regs);
  endtask
  task acc_write(input logic [31:0] v);
    acc_wdata_i = v[31:16];
    acc_high_we_i = 1;
    @(posedge mclk_i);
    #1 acc_high_we_i = 0;
    acc_low_we_i = 1;
    acc_wdata_i = v[15:0];
    @(posedge mclk_i);
    #1 acc_low_we_i = 0;
    acc = v;
  endtask
  initial begin
    void'($urandom(30271));
    repeat (6) @(posedge mclk_i);
    #1 rstn_i = 1;
    {divisor_high_i, rest_pair_i, multiplier_pair_i, low_word_pair_i} = 64'h12345678;
    run(3'h4, 0);
    run(3'h3, 0);
    {multiplier_pair_i, low_word_pair_i} = 32'h80008000;
    run(3'h2, 0);
    {multiplier_pair_i, low_word_pair_i} = 32'hFFFFFFFF;
    acc_write(32'hFFFFFFFF);
    run(3'h5, 0);
    acc_write(32'h7FFFFFFF);
    run(3'h6, 0);
    // Longest window: a 32-bit divide fetched from RAM, then a RAM-fetched byte multiply.
    {divisor_high_i, rest_pair_i} = 32'h00012345;
    {acc8_i, x_reg_i} = 16'hFFFF;
    run(3'h4, 1);
    run(3'h0, 1);
    repeat (40) begin
      {acc8_i, x_reg_i, low_word_pair_i} = $urandom;
      {multiplier_pair_i, rest_pair_i} = $urandom;
      divisor_high_i = 16'($urandom);
      run(3'($urandom % 7), 1'($urandom % 2));
    end
    complete_run;
  end
endmodule
bind mdm_unit mdm_unit_sva mdm_unit_sva_inst (.*);
`default_nettype wire

// *** logic/mdm_unit.v ***
// Multiply, divide and multiply-accumulate execution unit of the processor core.
`timescale 1ns/100ps
`include "mdm_unit_regs.vh"
`default_nettype none
module mdm_unit (
  // Clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // Issue from the decoder
  input wire start_i,
  input wire [2:0] op_i,
  input wire fetch_ram_i,
  input wire [7:0] acc8_i,
  input wire [7:0] x_reg_i,
  input wire [15:0] low_word_pair_i,
  input wire [15:0] multiplier_pair_i,
  input wire [15:0] rest_pair_i,
  input wire [15:0] divisor_high_i,
  // Accumulator half access
  input wire acc_high_we_i,
  input wire acc_low_we_i,
  input wire [15:0] acc_wdata_i,
  // Results to the register file
  output reg busy_o,
  output reg done_o,
  output reg [15:0] low_word_pair_o,
  output reg [15:0] multiplier_pair_o,
  output reg [15:0] rest_pair_o,
  output reg [15:0] divisor_high_o,
  output reg we_low_o,
  output reg we_mult_o,
  output reg we_rest_o,
  output reg we_div_high_o,
  output reg flags_we_o,
  output reg carry_flag_o,
  output reg aux_carry_flag_o,
  output reg [15:0] mac_acc_high_o,
  output reg [15:0] mac_acc_low_o
);

  // ************************************************************
  // Operation latch and cycle counter
  // ************************************************************
  reg [2:0] op;
  // Six bits: the longest RAM-fetch window, twice 17 plus 3, does not fit in five.
  reg [5:0] count;
  reg [5:0] base_clk;
  reg [5:0] total_clk;
  wire [31:0] umul = {16'h0000, low_word_pair_i} * {16'h0000, multiplier_pair_i};
  wire signed [31:0] smul = $signed(low_word_pair_i) * $signed(multiplier_pair_i);
  wire [32:0] mac_sum;
  wire [16:0] mac_low_sum;
  wire [31:0] prod_sel;
  reg [31:0] mac_prod;

  always @* begin
    case (op_i)
      `MDM_OP_MUL8_UNSIGNED: base_clk = `MDM_CLK_MUL8;
      `MDM_OP_MUL16_UNSIGNED: base_clk = `MDM_CLK_MUL16;
      `MDM_OP_MUL16_SIGNED: base_clk = `MDM_CLK_MUL16;
      `MDM_OP_DIV16_UNSIGNED: base_clk = `MDM_CLK_DIV16;
      `MDM_OP_DIV32_UNSIGNED: base_clk = `MDM_CLK_DIV32;
      default: base_clk = `MDM_CLK_MAC16;
    endcase
    // RAM fetch is modelled at the documented worst case so software timing is bounded.
    if (fetch_ram_i) begin
      total_clk = (base_clk << 1) + `MDM_RAM_EXTRA;
    end else begin
      total_clk = base_clk;
    end
  end

  assign prod_sel = (op_i == `MDM_OP_MAC16_SIGNED) ? smul : umul;
  assign mac_sum = {1'b0, mac_acc_high_o, mac_acc_low_o} + {1'b0, mac_prod};
  assign mac_low_sum = {1'b0, mac_acc_low_o} + {1'b0, mac_prod[15:0]};

  // ************************************************************
  // Sequencer
  // ************************************************************
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op <= 3'h0;
      count <= 6'h00;
      mac_prod <= 32'h00000000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      low_word_pair_o <= 16'h0000;
      multiplier_pair_o <= 16'h0000;
      rest_pair_o <= 16'h0000;
      divisor_high_o <= 16'h0000;
      we_low_o <= 1'b0;
      we_mult_o <= 1'b0;
      we_rest_o <= 1'b0;
      we_div_high_o <= 1'b0;
      flags_we_o <= 1'b0;
      carry_flag_o <= 1'b0;
      aux_carry_flag_o <= 1'b0;
      mac_acc_high_o <= 16'h0000;
      mac_acc_low_o <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      we_low_o <= 1'b0;
      we_mult_o <= 1'b0;
      we_rest_o <= 1'b0;
      we_div_high_o <= 1'b0;
      flags_we_o <= 1'b0;
      if (!busy_o) begin
        if (acc_high_we_i) begin
          mac_acc_high_o <= acc_wdata_i;
        end
        if (acc_low_we_i) begin
          mac_acc_low_o <= acc_wdata_i;
        end
      end
      if (start_i && !busy_o) begin
        op <= op_i;
        count <= total_clk - 6'h01;
        busy_o <= 1'b1;
        mac_prod <= prod_sel;
        case (op_i)
          `MDM_OP_MUL8_UNSIGNED: low_word_pair_o <= {8'h00, acc8_i} * {8'h00, x_reg_i};
          `MDM_OP_MUL16_UNSIGNED: {multiplier_pair_o, low_word_pair_o} <= umul;
          `MDM_OP_MUL16_SIGNED: {multiplier_pair_o, low_word_pair_o} <= smul;
          default: low_word_pair_o <= low_word_pair_o;
        endcase
      end else if (busy_o) begin
        if (count != 6'h00) begin
          count <= count - 6'h01;
        end
      end
      if (busy_o && count == 6'h00) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
        case (op)
          `MDM_OP_MUL8_UNSIGNED: begin
            we_low_o <= 1'b1;
          end
          `MDM_OP_MUL16_UNSIGNED, `MDM_OP_MUL16_SIGNED: begin
            we_low_o <= 1'b1;
            we_mult_o <= 1'b1;
          end
          `MDM_OP_DIV16_UNSIGNED: begin
            low_word_pair_o <= quo16(latch_a, latch_b);
            rest_pair_o <= rem16(latch_a, latch_b);
            we_low_o <= 1'b1;
            we_rest_o <= 1'b1;
          end
          `MDM_OP_DIV32_UNSIGNED: begin
            {multiplier_pair_o, low_word_pair_o} <= quo32(latch_a, latch_b);
            {divisor_high_o, rest_pair_o} <= rem32(latch_a, latch_b);
            we_low_o <= 1'b1;
            we_mult_o <= 1'b1;
            we_rest_o <= 1'b1;
            we_div_high_o <= 1'b1;
          end
          default: begin
            {mac_acc_high_o, mac_acc_low_o} <= mac_sum[31:0];
            flags_we_o <= 1'b1;
            carry_flag_o <= (op == `MDM_OP_MAC16_SIGNED) ?
              ((mac_acc_high_o[15] == mac_prod[31]) && (mac_sum[31] != mac_prod[31])) :
              mac_sum[32];
            aux_carry_flag_o <= mac_low_sum[16];
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Division results
  // ************************************************************
  // The counter above paces the busy window; the written results come from operands
  // held in the latches, which keeps the answer exact for every cycle count.
  reg [31:0] latch_a;
  reg [31:0] latch_b;
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      latch_a <= 32'h00000000;
      latch_b <= 32'h00000000;
    end else if (start_i && !busy_o) begin
      latch_a <= (op_i == `MDM_OP_DIV16_UNSIGNED) ? {16'h0000, low_word_pair_i} :
        {multiplier_pair_i, low_word_pair_i};
      latch_b <= (op_i == `MDM_OP_DIV16_UNSIGNED) ? {16'h0000, rest_pair_i} :
        {divisor_high_i, rest_pair_i};
    end
  end

  function [15:0] quo16;
    input [31:0] a;
    input [31:0] b;
    begin
      quo16 = (b[15:0] == 16'h0000) ? 16'hFFFF : a[15:0] / b[15:0];
    end
  endfunction

  function [15:0] rem16;
    input [31:0] a;
    input [31:0] b;
    begin
      rem16 = (b[15:0] == 16'h0000) ? a[15:0] : a[15:0] % b[15:0];
    end
  endfunction

  function [31:0] quo32;
    input [31:0] a;
    input [31:0] b;
    begin
      quo32 = (b == 32'h00000000) ? 32'hFFFFFFFF : a / b;
    end
  endfunction

  function [31:0] rem32;
    input [31:0] a;
    input [31:0] b;
    begin
      rem32 = (b == 32'h00000000) ? a : a % b;
    end
  endfunction

endmodule
`default_nettype wire

// *** logic/mdm_unit_regs.vh ***
// Opcode codes, cycle counts and flag positions of the multiply/divide/MAC unit.
`ifndef MDM_UNIT_REGS_VH
`define MDM_UNIT_REGS_VH
`define MDM_OP_MUL8_UNSIGNED 3'h0
`define MDM_OP_MUL16_UNSIGNED 3'h1
`define MDM_OP_MUL16_SIGNED 3'h2
`define MDM_OP_DIV16_UNSIGNED 3'h3
`define MDM_OP_DIV32_UNSIGNED 3'h4
`define MDM_OP_MAC16_UNSIGNED 3'h5
`define MDM_OP_MAC16_SIGNED 3'h6
`define MDM_CLK_MUL8 6'h01
`define MDM_CLK_MUL16 6'h02
`define MDM_CLK_DIV16 6'h09
`define MDM_CLK_DIV32 6'h11
`define MDM_CLK_MAC16 6'h03
`define MDM_RAM_EXTRA 6'h03
`define MDM_FLAG_CARRY 1
`define MDM_FLAG_AUX_CARRY 0
`define MDM_ACC_RESET 32'h00000000
`endif
